// file: fifo_port_pkg.sv
// Constants shared by the byte-port status block, its checker and its bench.
// Assumes one 10 MHz clock and a host cycle decoder that picks one register at a time.
package fifo_port_pkg;

  // ==========================================================================
  // Register selection and data widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_BYTE_PORT = 4'h4;
  localparam logic [3:0] OFF_FEATURES = 4'h8;

  // ==========================================================================
  // Status register field positions
  localparam int STS_VALID_BIT = 7;
  localparam int STS_CMD_READY_BIT = 6;
  localparam int STS_EXECUTE_BIT = 5;
  localparam int STS_DATA_AVAIL_BIT = 4;
  localparam int STS_EXPECT_BIT = 3;
  localparam int STS_RETRY_BIT = 1;

  // ==========================================================================
  // Feature flag positions and fixed values
  localparam int CAP_FIXED_BURST_BIT = 8;
  localparam int CAP_READY_IRQ_BIT = 7;
  localparam int CAP_FALLING_BIT = 6;
  localparam int CAP_RISING_BIT = 5;
  localparam int CAP_LOW_BIT = 4;
  localparam int CAP_HIGH_BIT = 3;
  localparam int CAP_OWNER_CHG_BIT = 2;
  localparam int CAP_VALID_IRQ_BIT = 1;
  localparam int CAP_RESP_IRQ_BIT = 0;
  localparam logic [31:0] CAP_RESET = 32'h0000_0000;

  // ==========================================================================
  // Fill value for reads with no response byte behind them
  localparam logic [7:0] EMPTY_BYTE = 8'hFF;

  // ==========================================================================
  // Timing: idle window during which an unprompted move to Ready is allowed
  localparam longint CLK_HZ = 10000000;
  localparam longint TIMEOUT_B_MS = 2000;
  localparam int TIMEOUT_B_CYCLES = int'((TIMEOUT_B_MS * CLK_HZ) / 1000);

  // ==========================================================================
  // Command life cycle
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READY = 3'b001,
    ST_RECEPTION = 3'b010,
    ST_EXECUTION = 3'b011,
    ST_COMPLETION = 3'b100
  } port_state_t;

endpackage

// file: byte_link_if.sv
// Valid/ready byte link between the status block and its command buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface byte_link_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  // ==========================================================================
  // Source drives data, sink answers with ready
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: two_entry_buffer.sv
// Small flip-flop FIFO holding command bytes on their way to the engine.
// Assumes a flush only while no push is offered; flush wins over push and pop.
`timescale 1ns/10ps
`default_nettype none
module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic flush,
  // Filling and draining sides
  byte_link_if.snk in_link,
  byte_link_if.src out_link
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] count_ff;
  logic push;
  logic pop;

  // ==========================================================================
  // Honest full and empty; a full buffer stalls the writer
  assign in_link.ready = (count_ff != FULL_CNT);
  assign out_link.valid = (count_ff != '0);
  assign out_link.data = mem_ff[rd_ptr_ff];
  assign push = in_link.valid && in_link.ready;
  assign pop = out_link.valid && out_link.ready;

  // Storage, written only at the write pointer
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_link.data;
    end
  end

  // Pointers wrap at the depth, not at a power of two
  always_ff @(posedge clk) begin
    if (srst || flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
      end
    end
  end

  // Fill level
  always_ff @(posedge clk) begin
    if (srst || flush) begin
      count_ff <= '0;
    end else if (push && !pop) begin
      count_ff <= count_ff + 1'b1;
    end else if (pop && !push) begin
      count_ff <= count_ff - 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: fifo_status_port.sv
// Host byte port, status register and feature flags of the command interface.
// Assumes the host cycle decoder shares clk, holds a request until acknowledged,
// and turns host_wait into wait-sync cycles on the bus.
`timescale 1ns/10ps
`default_nettype none
module fifo_status_port #(
  parameter int TIMEOUT_B_CYCLES = fifo_port_pkg::TIMEOUT_B_CYCLES,
  parameter bit AUTO_READY = 1'b1,
  parameter bit FIXED_BURST = 1'b1,
  parameter bit READY_IRQ = 1'b0,
  parameter bit FALLING_TRIG = 1'b0,
  parameter bit RISING_TRIG = 1'b0,
  parameter bit HIGH_TRIG = 1'b0,
  parameter bit VALID_IRQ = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Host register cycles
  input wire logic host_req,
  input wire logic host_write,
  input wire logic [fifo_port_pkg::ADDR_W-1:0] host_addr,
  input wire logic [fifo_port_pkg::DATA_W-1:0] host_wdata,
  output logic host_wait,
  output logic host_ack,
  output logic [fifo_port_pkg::DATA_W-1:0] host_rdata,
  // Command bytes towards the engine
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [fifo_port_pkg::BYTE_W-1:0] cmd_data,
  input wire logic cmd_last,
  // Execution control
  output logic exec_start,
  output logic cmd_abort,
  input wire logic exec_done,
  // Response bytes from the engine
  input wire logic rsp_valid,
  input wire logic [fifo_port_pkg::BYTE_W-1:0] rsp_data,
  input wire logic rsp_last,
  output logic rsp_ready,
  output logic rsp_rewind,
  // Visible state
  output fifo_port_pkg::port_state_t port_state
);

  // ==========================================================================
  // Declarations
  fifo_port_pkg::port_state_t state_ff;
  fifo_port_pkg::port_state_t nxt_state;
  logic expect_ff;
  logic nxt_expect;
  logic data_avail_ff;
  logic nxt_data_avail;
  logic ack_ff;
  logic [fifo_port_pkg::DATA_W-1:0] rdata_ff;
  logic [31:0] idle_cnt_ff;
  logic idle_window_open;
  logic exec_start_ff;
  logic abort_ff;
  logic rewind_ff;
  logic flush;
  logic take;
  logic sel_status;
  logic sel_port;
  logic sel_feat;
  logic port_wr;
  logic port_rd;
  logic sts_wr;
  logic wr_cmd_ready;
  logic wr_execute;
  logic wr_retry;
  logic byte_push;
  logic rsp_pop;
  logic [fifo_port_pkg::BYTE_W-1:0] port_byte;
  logic [fifo_port_pkg::DATA_W-1:0] status_word;
  logic [fifo_port_pkg::DATA_W-1:0] feature_word;
  logic [fifo_port_pkg::DATA_W-1:0] read_word;

  byte_link_if #(.WIDTH(fifo_port_pkg::BYTE_W)) push_link ();
  byte_link_if #(.WIDTH(fifo_port_pkg::BYTE_W)) drain_link ();

  // ==========================================================================
  // Register selection
  // A request is looked at once per cycle while no answer is pending
  assign sel_status = (host_addr == fifo_port_pkg::OFF_STATUS);
  assign sel_port = (host_addr == fifo_port_pkg::OFF_BYTE_PORT);
  assign sel_feat = (host_addr == fifo_port_pkg::OFF_FEATURES);

  // Writes of zero carry no meaning, so only ones are decoded
  assign wr_cmd_ready = host_wdata[fifo_port_pkg::STS_CMD_READY_BIT];
  assign wr_execute = host_wdata[fifo_port_pkg::STS_EXECUTE_BIT];
  assign wr_retry = host_wdata[fifo_port_pkg::STS_RETRY_BIT];

  // ==========================================================================
  // Command byte push and wait-sync
  // stall full buffer
  // A byte the buffer cannot hold keeps the cycle open instead of vanishing
  assign push_link.valid = host_req && !ack_ff && host_write && sel_port &&
                           (state_ff == fifo_port_pkg::ST_READY ||
                            (state_ff == fifo_port_pkg::ST_RECEPTION && expect_ff));
  assign push_link.data = host_wdata[fifo_port_pkg::BYTE_W-1:0];
  assign byte_push = push_link.valid && push_link.ready;
  assign host_wait = push_link.valid && !push_link.ready;
  assign take = host_req && !ack_ff && !host_wait;

  assign port_wr = take && host_write && sel_port;
  assign port_rd = take && !host_write && sel_port;
  assign sts_wr = take && host_write && sel_status;

  // ==========================================================================
  // Command buffer towards the engine
  two_entry_buffer #(
    .WIDTH(fifo_port_pkg::BYTE_W),
    .DEPTH(2)
  ) u_cmd_buf (
    .clk(clk),
    .srst(srst),
    .flush(flush),
    .in_link(push_link),
    .out_link(drain_link)
  );

  assign cmd_valid = drain_link.valid;
  assign cmd_data = drain_link.data;
  assign drain_link.ready = cmd_ready;

  // ==========================================================================
  // Idle window timer
  // Restarts on every entry to Idle and saturates, so a long idle stays closed
  always_ff @(posedge clk) begin
    if (srst || state_ff != fifo_port_pkg::ST_IDLE) begin
      idle_cnt_ff <= '0;
    end else if (idle_window_open) begin
      idle_cnt_ff <= idle_cnt_ff + 32'h0000_0001;
    end
  end

  assign idle_window_open = (idle_cnt_ff < 32'(TIMEOUT_B_CYCLES));

  // ==========================================================================
  // Next state of the command life cycle
  // Writes with more than one field set are left without effect
  always_comb begin
    logic one_hot;
    one_hot = (32'(wr_cmd_ready) + 32'(wr_execute) + 32'(wr_retry)) == 32'h1;
    nxt_state = state_ff;
    nxt_expect = expect_ff;
    nxt_data_avail = data_avail_ff;
    case (state_ff)
      fifo_port_pkg::ST_IDLE: begin
        if (sts_wr && one_hot && wr_cmd_ready) begin
          nxt_state = fifo_port_pkg::ST_READY;
        end else if (AUTO_READY && idle_window_open && !drain_link.valid) begin
          nxt_state = fifo_port_pkg::ST_READY;
        end
        nxt_expect = 1'b0;
        nxt_data_avail = 1'b0;
      end
      fifo_port_pkg::ST_READY: begin
        if (byte_push) begin
          nxt_state = fifo_port_pkg::ST_RECEPTION;
          nxt_expect = 1'b1;
        end
      end
      fifo_port_pkg::ST_RECEPTION: begin
        if (sts_wr && one_hot && wr_cmd_ready) begin
          nxt_state = fifo_port_pkg::ST_IDLE;
          nxt_expect = 1'b0;
          nxt_data_avail = 1'b0;
        end else if (sts_wr && one_hot && wr_execute && !expect_ff) begin
          nxt_state = fifo_port_pkg::ST_EXECUTION;
        end else if (cmd_last) begin
          nxt_expect = 1'b0;
        end
      end
      fifo_port_pkg::ST_EXECUTION: begin
        if (sts_wr && one_hot && wr_cmd_ready) begin
          nxt_state = fifo_port_pkg::ST_IDLE;
        end else if (exec_done) begin
          nxt_state = fifo_port_pkg::ST_COMPLETION;
          nxt_data_avail = 1'b1;
        end
        nxt_expect = 1'b0;
      end
      fifo_port_pkg::ST_COMPLETION: begin
        if (sts_wr && one_hot && wr_cmd_ready) begin
          nxt_state = fifo_port_pkg::ST_IDLE;
          nxt_data_avail = 1'b0;
        end else if (sts_wr && one_hot && wr_retry) begin
          nxt_data_avail = 1'b1;
        end else if (rsp_pop && rsp_last) begin
          nxt_data_avail = 1'b0;
        end
      end
      default: begin
        nxt_state = fifo_port_pkg::ST_IDLE;
        nxt_expect = 1'b0;
        nxt_data_avail = 1'b0;
      end
    endcase
  end

  // State and status flags
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= fifo_port_pkg::ST_IDLE;
      expect_ff <= 1'b0;
      data_avail_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      expect_ff <= nxt_expect;
      data_avail_ff <= nxt_data_avail;
    end
  end

  // ==========================================================================
  // Engine control pulses
  // Abort also empties the buffer so the next command starts clean
  assign flush = abort_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      exec_start_ff <= 1'b0;
      abort_ff <= 1'b0;
      rewind_ff <= 1'b0;
    end else begin
      exec_start_ff <= (state_ff == fifo_port_pkg::ST_RECEPTION) &&
                       (nxt_state == fifo_port_pkg::ST_EXECUTION);
      abort_ff <= (state_ff != fifo_port_pkg::ST_IDLE) &&
                  (state_ff != fifo_port_pkg::ST_READY) &&
                  (nxt_state == fifo_port_pkg::ST_IDLE);
      rewind_ff <= (state_ff == fifo_port_pkg::ST_COMPLETION) && sts_wr &&
                   wr_retry && !wr_cmd_ready && !wr_execute;
    end
  end

  assign exec_start = exec_start_ff;
  assign cmd_abort = abort_ff;
  assign rsp_rewind = rewind_ff;

  // ==========================================================================
  // Response byte pop
  // Only a read while data is shown consumes a byte from the engine
  assign rsp_pop = port_rd && (state_ff == fifo_port_pkg::ST_COMPLETION) &&
                   data_avail_ff && rsp_valid;
  assign rsp_ready = rsp_pop;

  assign port_byte = rsp_pop ? rsp_data : fifo_port_pkg::EMPTY_BYTE;

  // ==========================================================================
  // Read words
  // Execute and retry are write-only and read back as zero
  always_comb begin
    status_word = '0;
    status_word[fifo_port_pkg::STS_VALID_BIT] = 1'b1;
    status_word[fifo_port_pkg::STS_CMD_READY_BIT] = (state_ff == fifo_port_pkg::ST_READY);
    status_word[fifo_port_pkg::STS_DATA_AVAIL_BIT] = data_avail_ff;
    status_word[fifo_port_pkg::STS_EXPECT_BIT] = expect_ff;
  end

  always_comb begin
    feature_word = fifo_port_pkg::CAP_RESET;
    feature_word[fifo_port_pkg::CAP_FIXED_BURST_BIT] = FIXED_BURST;
    feature_word[fifo_port_pkg::CAP_READY_IRQ_BIT] = READY_IRQ;
    feature_word[fifo_port_pkg::CAP_FALLING_BIT] = FALLING_TRIG;
    feature_word[fifo_port_pkg::CAP_RISING_BIT] = RISING_TRIG;
    feature_word[fifo_port_pkg::CAP_HIGH_BIT] = HIGH_TRIG;
    feature_word[fifo_port_pkg::CAP_LOW_BIT] = 1'b1;
    feature_word[fifo_port_pkg::CAP_OWNER_CHG_BIT] = 1'b1;
    feature_word[fifo_port_pkg::CAP_VALID_IRQ_BIT] = VALID_IRQ;
    feature_word[fifo_port_pkg::CAP_RESP_IRQ_BIT] = 1'b1;
  end

  // Unmapped selections read as zero
  always_comb begin
    if (sel_status) begin
      read_word = status_word;
    end else if (sel_port) begin
      read_word = {{(fifo_port_pkg::DATA_W - fifo_port_pkg::BYTE_W){1'b0}}, port_byte};
    end else if (sel_feat) begin
      read_word = feature_word;
    end else begin
      read_word = '0;
    end
  end

  // ==========================================================================
  // Answer to the host
  // One-cycle acknowledge; the host must drop its request on it
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= take;
      if (take && !host_write) begin
        rdata_ff <= read_word;
      end
    end
  end

  assign host_ack = ack_ff;
  assign host_rdata = rdata_ff;
  assign port_state = state_ff;

endmodule
`default_nettype wire

// file: fifo_status_port_sva.sv
// Checker for the host byte port and status state machine.
// Assumes it is bound to fifo_status_port and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fifo_status_port_checker #(
  parameter int TIMEOUT_B_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Host register cycles
  input wire logic host_req,
  input wire logic host_write,
  input wire logic [3:0] host_addr,
  input wire logic [31:0] host_wdata,
  input wire logic host_wait,
  input wire logic host_ack,
  input wire logic [31:0] host_rdata,
  // Control and state
  input wire logic cmd_abort,
  input wire fifo_port_pkg::port_state_t port_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // =========================================================================
  // Decoded host cycles and states
  wire logic take = host_req && !host_ack && !host_wait;
  wire logic sts_wr = take && host_write && host_addr == fifo_port_pkg::OFF_STATUS;
  wire logic port_wr = take && host_write && host_addr == fifo_port_pkg::OFF_BYTE_PORT;
  wire logic port_rd = take && !host_write && host_addr == fifo_port_pkg::OFF_BYTE_PORT;
  wire logic cap_rd = take && !host_write && host_addr == fifo_port_pkg::OFF_FEATURES;
  wire logic in_idle = port_state == fifo_port_pkg::ST_IDLE;
  wire logic in_rdy = port_state == fifo_port_pkg::ST_READY;
  wire logic in_rcv = port_state == fifo_port_pkg::ST_RECEPTION;
  int idle_cnt_ff;
  // Cycles spent in Idle, saturating at the window length
  always_ff @(posedge clk) begin
    if (srst || !in_idle) idle_cnt_ff <= 0;
    else if (idle_cnt_ff < TIMEOUT_B_CYCLES) idle_cnt_ff <= idle_cnt_ff + 1;
  end
  // =========================================================================
  // Properties
  sequence s_byte_in;
    port_wr && in_rdy;
  endsequence
  sequence s_abort_out;
    in_idle ##[0:1] cmd_abort;
  endsequence
  property p_answer;
    take |=> host_ack ##1 !host_ack;
  endproperty
  property p_stall;
    host_req && host_wait |=> !host_ack;
  endproperty
  property p_features;
    cap_rd |=> host_rdata[31:9] == '0 && host_rdata[4] && host_rdata[2] && host_rdata[0];
  endproperty
  property p_idle_read;
    port_rd && in_idle |=> host_rdata == 32'h0000_00FF && in_idle;
  endproperty
  property p_idle_drop;
    port_wr && in_idle |=> in_idle;
  endproperty
  property p_ready_read;
    port_rd && in_rdy |=> host_rdata == 32'h0000_00FF && in_rdy;
  endproperty
  property p_first_byte;
    s_byte_in |=> in_rcv;
  endproperty
  property p_abort;
    sts_wr && host_wdata == 32'h0000_0040 && in_rcv |=> s_abort_out;
  endproperty
  property p_idle_go;
    sts_wr && host_wdata == 32'h0000_0040 && in_idle |=> in_rdy;
  endproperty
  property p_idle_ignore;
    sts_wr && host_wdata inside {32'h0000_0002, 32'h0000_0020} && in_idle |=> in_idle;
  endproperty
  property p_ready_ignore;
    sts_wr && host_wdata inside {32'h0000_0002, 32'h0000_0020, 32'h0000_0040} && in_rdy
      |=> in_rdy;
  endproperty
  property p_idle_hold;
    in_idle && idle_cnt_ff >= TIMEOUT_B_CYCLES && !sts_wr |=> in_idle;
  endproperty
  a_answer: assert property (p_answer) else $error("taken request not acked once");
  a_stall: assert property (p_stall) else $error("stalled write was acked");
  a_features: assert property (p_features) else $error("feature flags wrong");
  a_idle_read: assert property (p_idle_read) else $error("idle port read not FF");
  a_idle_drop: assert property (p_idle_drop) else $error("idle port write moved state");
  a_ready_read: assert property (p_ready_read) else $error("ready port read wrong");
  a_first_byte: assert property (p_first_byte) else $error("first byte missed reception");
  a_abort: assert property (p_abort) else $error("reception abort wrong");
  a_idle_go: assert property (p_idle_go) else $error("idle did not go ready");
  a_idle_ignore: assert property (p_idle_ignore) else $error("idle left on lone field");
  a_ready_ignore: assert property (p_ready_ignore) else $error("ready left on lone field");
  a_idle_hold: assert property (p_idle_hold) else $error("left idle after window");
endmodule
bind fifo_status_port fifo_status_port_checker #(.TIMEOUT_B_CYCLES(TIMEOUT_B_CYCLES)) chk_u (
  .clk(clk),
  .srst(srst),
  .host_req(host_req),
  .host_write(host_write),
  .host_addr(host_addr),
  .host_wdata(host_wdata),
  .host_wait(host_wait),
  .host_ack(host_ack),
  .host_rdata(host_rdata),
  .cmd_abort(cmd_abort),
  .port_state(port_state)
);
`default_nettype wire

// file: cmd_engine_model.sv
// Behavioural command engine sitting behind the byte port.
// Assumes one clock; answers are driven off the falling edge.
`timescale 1ns/10ps
`default_nettype none
module cmd_engine_model #(
  parameter int CMD_LEN = 4
) (
  // Clock, reset and stall control
  input wire logic clk,
  input wire logic srst,
  input wire logic stall,
  // From the port
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic exec_start,
  input wire logic cmd_abort,
  input wire logic rsp_ready,
  input wire logic rsp_rewind,
  // Back to the port
  output logic cmd_ready = 1'b0,
  output logic cmd_last = 1'b0,
  output logic exec_done = 1'b0,
  output logic rsp_valid = 1'b0,
  output logic [7:0] rsp_data = 8'h5A,
  output logic rsp_last = 1'b0
);
  logic [7:0] got[$];
  int cnt = 0;
  int busy = 0;
  logic fire = 1'b0;
  logic done = 1'b0;
  // Take bytes at the edge the port hands them over; abort drops them all
  always @(posedge clk) begin
    if (srst || cmd_abort) begin
      cnt = 0;
      busy = 0;
      done = 1'b0;
      got.delete();
    end else if (cmd_valid && cmd_ready) begin
      got.push_back(cmd_data);
      cnt++;
      if (cnt == CMD_LEN) fire = 1'b1;
    end
    if (exec_start === 1'b1) busy = 50;
    // The response echoes the command, one byte per taken read
    if (rsp_ready === 1'b1 && got.size() > 0) void'(got.pop_front());
  end
  // Answers; the unused response byte keeps toggling so no stale value passes
  always @(negedge clk) begin
    if (busy == 1) done = 1'b1;
    cmd_ready <= !stall;
    cmd_last <= fire;
    fire = 1'b0;
    exec_done <= (busy == 1);
    if (busy > 0) busy--;
    rsp_valid <= done && got.size() > 0;
    rsp_last <= got.size() == 1;
    rsp_data <= (got.size() > 0) ? got[0] : ~rsp_data;
  end
endmodule
`default_nettype wire

// file: tb_secure_module_fifo_status_port.sv
// Self-checking bench for the byte port and status machine.
// Assumes the checker is bound in and the engine model answers commands.
`timescale 1ns/10ps
`default_nettype none
module tb_secure_module_fifo_status_port;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic host_req = 1'b0;
  logic host_write = 1'b0;
  logic [3:0] host_addr = 4'h0;
  logic [31:0] host_wdata = 32'h0;
  logic [31:0] host_rdata, q;
  logic [7:0] cmd_data, rsp_data;
  logic host_wait, host_ack, cmd_valid, cmd_ready, cmd_last, exec_start, cmd_abort;
  logic exec_done, rsp_valid, rsp_last, rsp_ready, rsp_rewind;
  logic stall = 1'b1;
  logic waited = 1'b0;
  fifo_port_pkg::port_state_t port_state;
  int mismatches = 0;
  int samples_checked = 0;
  int n_abort = 0;
  int n_exec = 0;
  int m_st = 0;
  logic m_exp = 1'b0;
  logic [7:0] sent[$];
  logic [31:0] codes[3] = '{32'h40, 32'h20, 32'h2};
  // =========================================================================
  // Clock, design and engine
  always #50 clk = ~clk;
  fifo_status_port #(.TIMEOUT_B_CYCLES(20), .AUTO_READY(1'b0)) dut_u (
    .clk(clk), .srst(srst), .host_req(host_req), .host_write(host_write),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wait(host_wait),
    .host_ack(host_ack), .host_rdata(host_rdata), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_data(cmd_data), .cmd_last(cmd_last),
    .exec_start(exec_start), .cmd_abort(cmd_abort), .exec_done(exec_done),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
    .rsp_ready(rsp_ready), .rsp_rewind(rsp_rewind), .port_state(port_state));
  cmd_engine_model #(.CMD_LEN(4)) eng_u (
    .clk(clk), .srst(srst), .stall(stall), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .exec_start(exec_start), .cmd_abort(cmd_abort), .rsp_ready(rsp_ready),
    .rsp_rewind(rsp_rewind), .cmd_ready(cmd_ready), .cmd_last(cmd_last),
    .exec_done(exec_done), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_last(rsp_last));
  // Count control pulses from the port
  always @(posedge clk) begin
    if (cmd_abort === 1'b1) n_abort++;
    if (exec_start === 1'b1) n_exec++;
  end
  // =========================================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One host cycle; request held until ack, dropped inside the ack cycle
  task automatic hx(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    host_req = 1'b1;
    host_write = wr;
    host_addr = a;
    host_wdata = d;
    do begin
      @(negedge clk);
      n++;
      if (host_wait === 1'b1) waited = 1'b1;
    end while (host_ack !== 1'b1 && n < 200);
    if (n >= 200) mismatches++;
    q = host_rdata;
    host_req = 1'b0;
  endtask
  task automatic sts_chk();
    hx(1'b0, fifo_port_pkg::OFF_STATUS, 32'h0);
    chk({24'h0, q[7:0]}, {24'h0, 1'b1, m_st == 1, 2'b00, m_exp, 3'b000});
    chk({29'h0, port_state}, 32'(m_st));
  endtask
  // Status write with the expected model move
  task automatic wr_sts(input logic [31:0] d);
    hx(1'b1, fifo_port_pkg::OFF_STATUS, d);
    if (d == 32'h40 && m_st == 0) m_st = 1;
    else if (d == 32'h40 && m_st == 2) m_st = 0;
    else if (d == 32'h20 && m_st == 2 && !m_exp) m_st = 3;
    if (m_st != 2) m_exp = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] b);
    hx(1'b1, fifo_port_pkg::OFF_BYTE_PORT, {24'h0, b});
    if (m_st == 1) m_st = 2;
    if (m_st == 2 && (m_exp || sent.size() == 0)) sent.push_back(b);
    m_exp = (m_st == 2 && sent.size() < 4);
  endtask
  task automatic rd_port();
    hx(1'b0, fifo_port_pkg::OFF_BYTE_PORT, 32'h0);
    chk(q, 32'h0000_00FF);
  endtask
  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // =========================================================================
  // Main sequence
  initial begin
    int k;
    k = $urandom(32'hF8AE7E1A);
    repeat (6) @(negedge clk);
    srst = 1'b0;
    hx(1'b0, fifo_port_pkg::OFF_FEATURES, 32'h0);
    chk(q, 32'h0000_0115);
    hx(1'b1, fifo_port_pkg::OFF_FEATURES, $urandom);
    hx(1'b0, fifo_port_pkg::OFF_FEATURES, 32'h0);
    chk(q, 32'h0000_0115);
    sts_chk();
    foreach (codes[i]) if (i > 0) wr_sts(codes[i]);
    sts_chk();
    wr_byte(8'($urandom));
    rd_port();
    repeat (30) @(negedge clk);
    sts_chk();
    wr_sts(32'h40);
    sts_chk();
    foreach (codes[i]) wr_sts(codes[i]);
    sts_chk();
    rd_port();
    // Abort a command whose byte still sits in the stalled buffer
    wr_byte(8'($urandom));
    sts_chk();
    rd_port();
    wr_sts(32'h40);
    sts_chk();
    chk(n_abort, 1);
    sent.delete();
    // Full command; third byte meets a full buffer and must stall
    wr_sts(32'h40);
    wr_byte(8'($urandom));
    wr_sts(32'h2);
    wr_sts(32'h20);
    sts_chk();
    wr_byte(8'($urandom));
    sts_chk();
    waited = 1'b0;
    fork
      wr_byte(8'($urandom));
      begin
        repeat (10) @(negedge clk);
        stall = 1'b0;
      end
    join
    chk(waited, 1);
    wr_byte(8'($urandom));
    // poll the status instead of assuming when expect drops
    k = 0;
    do begin
      hx(1'b0, fifo_port_pkg::OFF_STATUS, 32'h0);
      k++;
    end while (q[3] !== 1'b0 && k < 20);
    sts_chk();
    chk(eng_u.got.size(), sent.size());
    foreach (sent[i]) chk(eng_u.got[i], sent[i]);
    wr_sts(32'h20);
    sts_chk();
    chk(n_exec, 1);
    // Engine echoes the command as its response; poll until data is shown
    k = 0;
    do begin
      hx(1'b0, fifo_port_pkg::OFF_STATUS, 32'h0);
      k++;
    end while (q[4] !== 1'b1 && k < 60);
    m_st = 4;
    foreach (sent[i]) begin
      hx(1'b0, fifo_port_pkg::OFF_BYTE_PORT, 32'h0);
      chk(q, {24'h0, sent[i]});
    end
    sts_chk();
    rd_port();
    complete_run();
  end
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #2000000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
